/* bench/pmbus_host_model.sv */
// Purpose: Host model that writes and reads the byte and clears faults.
// Assumes: Requests are launched at the falling edge of clk_i.
// Notes:   Single-byte accesses with no wait states; released lines change.
`timescale 1ns/10ps
module pmbus_host_model (
	input  wire logic       clk_i,   // System clock.
	output logic            wr_o,    // Write strobe.
	output logic            rd_o,    // Read strobe.
	output logic      [7:0] code_o,  // Command code.
	output logic      [7:0] wdata_o, // Write byte.
	input  wire logic [7:0] rdata_i, // Read byte.
	input  wire logic       ack_i,   // Access taken.
	output logic            sclr_o,  // Status bit clear pulse.
	output logic            aclr_o   // Clear-all pulse.
);
	// ==================================================================
	// Idle levels at time zero.
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		code_o = 8'hFF;
		wdata_o = 8'h00;
		sclr_o = 1'b0;
		aclr_o = 1'b0;
	end

	// One access; the answer stands in the cycle after the taking edge.
	// Released lines show an unused code and inverted data, not old values.
	task automatic access(input logic w, input logic [7:0] c, input logic [7:0] d,
			output logic [7:0] q, output logic a);
		@(negedge clk_i);
		wr_o <= w;
		rd_o <= !w;
		code_o <= c;
		wdata_o <= d;
		@(negedge clk_i);
		q = rdata_i;
		a = ack_i;
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		code_o <= 8'hFF;
		wdata_o <= ~d;
	endtask

	// One-cycle clear, either of the status bit or of all faults.
	task automatic clear(input logic all);
		@(negedge clk_i);
		sclr_o <= !all;
		aclr_o <= all;
		@(negedge clk_i);
		sclr_o <= 1'b0;
		aclr_o <= 1'b0;
	endtask
endmodule

/* bench/tb_undertemp_fault_response.sv */
// Purpose: Self-checking bench for the under-temperature fault response.
// Assumes: One microsecond is 40 cycles; the time unit input is kept small.
// Notes:   Timing windows allow for the free-running microsecond prescaler.
`include "ut_fault_defs.svh"
`timescale 1ns/10ps
module tb_undertemp_fault_response;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr, rd, ack, sclr, aclr, out_en, sts;
	logic [7:0]  code, wdata, rdata, q, lfsr_q = 8'h50;
	logic [15:0] unit_us = 16'h0001;
	logic        fault = 1'b0;
	logic        pin = 1'b0;
	logic        op_on = 1'b0;
	logic        shdn = 1'b0;
	logic        a;
	int          failures = 0;
	int          cmp_count = 0;
	int          t, r, d;
	int          retry_set [4] = '{0, 1, 3, 6};
	logic [7:0]  exp_q [$];

	// ==================================================================
	// Clock and the two sides of the block.
	always #12.5 clk = ~clk;
	pmbus_host_model u_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .code_o(code),
		.wdata_o(wdata), .rdata_i(rdata), .ack_i(ack), .sclr_o(sclr), .aclr_o(aclr));
	undertemp_fault_response u_dut (.CLK_I(clk), .RESET_I(rst), .CMD_WR_I(wr),
		.CMD_RD_I(rd), .CMD_CODE_I(code), .CMD_WDATA_I(wdata), .CMD_RDATA_O(rdata),
		.CMD_ACK_O(ack), .UNIT_US_I(unit_us), .UT_FAULT_I(fault), .STATUS_CLR_I(sclr),
		.CLEAR_FAULTS_I(aclr), .CTRL_PIN_I(pin), .OP_ON_I(op_on), .OTHER_SHDN_I(shdn),
		.OUT_EN_O(out_en), .FAULT_STS_O(sts));

	// ==================================================================
	// Helpers: compare, random source, delay table and output watchers.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	// Units per delay code; codes 1 and 2 both give two units.
	function automatic int units(input int c);
		int tbl [8] = '{1, 2, 2, 8, 16, 32, 64, 128};
		return tbl[c];
	endfunction

	// Waits for a level of the output enable; t reaches max if it never comes.
	task automatic wait_out(input logic v, input int max, output int n);
		n = 0;
		while (out_en !== v && n < max) begin
			@(negedge clk);
			n++;
		end
	endtask

	// Counts restarts, seen as rising edges of the output enable.
	task automatic count_rises(input int cyc, output int n);
		logic prev;
		prev = out_en;
		n = 0;
		repeat (cyc) begin
			@(negedge clk);
			if (out_en === 1'b1 && prev !== 1'b1) n++;
			prev = out_en;
		end
	endtask

	// Writes the byte and reads it back against the bench's expected-value queue.
	task automatic setcfg(input logic [7:0] b);
		u_host.access(1'b1, `UTR_CMD_CODE, b, q, a);
		exp_q.push_back(b);
		check(a, 1'b1);
		u_host.access(1'b0, `UTR_CMD_CODE, 8'h00, q, a);
		check(q, exp_q.pop_front());
	endtask

	// Turns the output off and on again by pin or by command.
	task automatic on_cycle(input logic by_pin);
		@(negedge clk);
		if (by_pin) pin <= 1'b0;
		else op_on <= 1'b0;
		repeat (4) @(negedge clk);
		pin <= 1'b1;
		op_on <= 1'b1;
		wait_out(1'b1, 10, t);
		check(out_en, 1'b1);
		check(sts, 1'b0);
	endtask

	// Removes the fault, clears all and restarts the output.
	task automatic restore();
		fault <= 1'b0;
		u_host.clear(1'b1);
		on_cycle(1'b0);
	endtask

	task automatic wrap_up();
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==================================================================
	// Watchdog sized well above the longest expected run.
	initial begin
		#1500000;
		failures++;
		wrap_up();
	end

	// ==================================================================
	// Main sequence.
	initial begin
		repeat (6) @(negedge clk);
		rst <= 1'b0;
		u_host.access(1'b0, `UTR_CMD_CODE, 8'h00, q, a);
		check(q, `UTR_RESET_VAL);
		check(out_en, 1'b0);
		repeat (4) begin
			lfsr_q = lfsr(lfsr_q);
			setcfg(lfsr_q);
		end
		u_host.access(1'b0, 8'h53, 8'h00, q, a);
		check({a, q}, 9'h000);
		on_cycle(1'b1);
		// Ignore: output keeps regulating, status still records the fault.
		setcfg(8'h00);
		fault <= 1'b1;
		wait_out(1'b0, 300, t);
		check(t, 300);
		check(sts, 1'b1);
		restore();
		// Off time before the first restart for every delay code, the unit alternating between 1 and 2 us.
		for (int c = 0; c < 8; c++) begin
			unit_us = 16'(1 + c % 2);
			setcfg({2'b10, 3'h1, 3'(c)});
			fault <= 1'b1;
			wait_out(1'b0, 5, t);
			check(out_en, 1'b0);
			wait_out(1'b1, 11000, t);
			d = units(c) * int'(unit_us) * 40;
			check(t >= d - 40 && t <= d + 3, 1'b1);
			restore();
		end
		unit_us = 16'h0001;
		// Run on for the delay, then drop and stay off with no retries.
		setcfg(8'h43);
		fault <= 1'b1;
		wait_out(1'b0, 1000, t);
		d = units(3) * 40;
		check(t >= d - 40 && t <= d + 3, 1'b1);
		count_rises(400, r);
		check(r, 0);
		restore();
		// Exact restart counts, then off until cleared by either clear.
		for (int i = 0; i < 4; i++) begin
			r = retry_set[i];
			setcfg({2'b10, 3'(r), 3'h0});
			fault <= 1'b1;
			count_rises((r + 2) * 110, t);
			check(t, r);
			check(out_en, 1'b0);
			fault <= 1'b0;
			u_host.clear(i[0]);
			wait_out(1'b1, 5, t);
			check({out_en, sts}, 2'b10);
		end
		// Latch off until an off-then-on command sequence.
		setcfg(8'hC0);
		fault <= 1'b1;
		wait_out(1'b0, 3, t);
		count_rises(400, r);
		check(out_en, 1'b0);
		check(r, 0);
		fault <= 1'b0;
		on_cycle(1'b0);
		// Endless retries until another fault forces shutdown.
		setcfg(8'hB8);
		fault <= 1'b1;
		count_rises(1500, r);
		check(r >= 7, 1'b1);
		shdn <= 1'b1;
		count_rises(400, r);
		check(out_en, 1'b0);
		check(r, 0);
		shdn <= 1'b0;
		fault <= 1'b0;
		on_cycle(1'b1);
		wrap_up();
	end
endmodule

/* logic/delay_timer.sv */
// Purpose: Counts a number of time units, each a number of microsecond ticks.
// Assumes: us_tick_i is a one-cycle enable from a free-running divider.
// Notes:   A start reloads the timer even while it runs.
`timescale 1ns/10ps
module delay_timer (
	input  wire logic        clk_i,     // System clock.
	input  wire logic        rst_i,     // Asynchronous reset, active high.
	input  wire logic        start_i,   // Load and start, one-cycle pulse.
	input  wire logic        us_tick_i, // Microsecond enable pulse.
	input  wire logic [15:0] unit_us_i, // Length of one unit in microseconds.
	input  wire logic [7:0]  units_i,   // Number of units to count.
	output logic             done_o     // One-cycle pulse at expiry.
);

	logic [15:0] us_cnt_q;
	logic [7:0]  unit_cnt_q;
	logic        busy_q;
	logic        done_q;
	wire  [15:0] unit_len = (unit_us_i == 16'h0000) ? 16'h0001 : unit_us_i;
	wire         unit_end = busy_q && us_tick_i && (us_cnt_q <= 16'h0001);
	wire         last     = unit_end && (unit_cnt_q <= 8'h01);

	assign done_o = done_q;

	// ======================================================================
	// Counting. Up to one microsecond of phase error at start is accepted
	// so that the prescaler can be shared with nothing to resynchronise.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			us_cnt_q   <= 16'h0000;
			unit_cnt_q <= 8'h00;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
		end else if (start_i) begin
			us_cnt_q   <= unit_len;
			unit_cnt_q <= units_i;
			busy_q     <= 1'b1;
			done_q     <= 1'b0;
		end else begin
			done_q <= last;
			if (last) begin
				busy_q <= 1'b0;
			end else if (unit_end) begin
				us_cnt_q   <= unit_len;
				unit_cnt_q <= unit_cnt_q - 8'h01;
			end else if (busy_q && us_tick_i) begin
				us_cnt_q <= us_cnt_q - 16'h0001;
			end
		end
	end

	// ======================================================================
	// The final tick of the final unit must raise done on the next edge.
	chk_timer_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
		last && !start_i |=> done_o && !busy_q)
		else $error("Delay timer did not expire on its final unit.");

endmodule

/* logic/undertemp_fault_response.sv */
// Purpose: Under-temperature fault response: ignore, run on, retry or latch off.
// Assumes: Command strobes come from the management bus layer on CLK_I;
//          the time unit value is the decoded contents of the unit register.
// Notes:   The control pin is asynchronous and is synchronised here.
`include "ut_fault_defs.svh"
`timescale 1ns/10ps
module undertemp_fault_response (
	input  wire logic        CLK_I,          // 40 MHz clock.
	input  wire logic        RESET_I,        // Asynchronous reset, active high.
	input  wire logic        CMD_WR_I,       // Byte write strobe, one cycle.
	input  wire logic        CMD_RD_I,       // Byte read strobe, one cycle.
	input  wire logic [7:0]  CMD_CODE_I,     // Command code of the access.
	input  wire logic [7:0]  CMD_WDATA_I,    // Write data byte.
	output logic      [7:0]  CMD_RDATA_O,    // Read data byte.
	output logic             CMD_ACK_O,      // Access to this command taken.
	input  wire logic [15:0] UNIT_US_I,      // Time unit in microseconds.
	input  wire logic        UT_FAULT_I,     // Under-temperature fault present.
	input  wire logic        STATUS_CLR_I,   // Clear of the status bit, pulse.
	input  wire logic        CLEAR_FAULTS_I, // Clear-all command, pulse.
	input  wire logic        CTRL_PIN_I,     // Remote control pin, high is on.
	input  wire logic        OP_ON_I,        // Operation command on state.
	input  wire logic        OTHER_SHDN_I,   // Another fault forces shutdown.
	output logic             OUT_EN_O,       // Output regulation enable.
	output logic             FAULT_STS_O     // Sticky under-temperature status.
);

	ut_fault_pkg::state_t st_q;
	ut_fault_pkg::state_t st_d;
	logic [7:0]           cfg_q;
	logic [7:0]           rdata_q;
	logic                 ack_q;
	logic                 ctrl_s1_q;
	logic                 ctrl_s2_q;
	logic                 cmd_on_q;
	logic                 sts_q;
	logic                 out_en_q;
	logic [2:0]           tries_q;
	logic [2:0]           tries_d;
	logic [5:0]           tick_cnt_q;
	logic                 us_tick_q;
	logic                 tmr_start;
	logic                 tmr_done;
	logic [7:0]           units;

	// ======================================================================
	// Decode and field selection.
	ut_fault_pkg::cfg_t cfg;
	assign cfg = ut_fault_pkg::cfg_t'(cfg_q);
	wire hit       = (CMD_CODE_I == `UTR_CMD_CODE);
	wire cmd_on    = ctrl_s2_q && OP_ON_I;
	wire on_rise   = cmd_on && !cmd_on_q && !OTHER_SHDN_I;
	wire kill      = !cmd_on || OTHER_SHDN_I;
	wire clr_evt   = STATUS_CLR_I || CLEAR_FAULTS_I;
	wire no_retry  = (cfg.retries == `UTR_RETRY_NONE);
	wire endless   = (cfg.retries == `UTR_RETRY_FOREVER);
	wire more_left = endless || (tries_q < cfg.retries);
	wire in_fault  = (st_q == ut_fault_pkg::ST_WAIT) || (st_q == ut_fault_pkg::ST_TRY) ||
	                 (st_q == ut_fault_pkg::ST_LATCH);

	assign CMD_RDATA_O = rdata_q;
	assign CMD_ACK_O   = ack_q;
	assign OUT_EN_O    = out_en_q;
	assign FAULT_STS_O = sts_q;

	// ======================================================================
	// Delay code to unit count; codes 1 and 2 sit in named constants.
	always_comb begin
		case (cfg.dly)
			3'h0:    units = `UTR_UNITS_0;
			3'h1:    units = `UTR_UNITS_1;
			3'h2:    units = `UTR_UNITS_2;
			3'h3:    units = `UTR_UNITS_3;
			3'h4:    units = `UTR_UNITS_4;
			3'h5:    units = `UTR_UNITS_5;
			3'h6:    units = `UTR_UNITS_6;
			default: units = `UTR_UNITS_7;
		endcase
	end

	// ======================================================================
	// Microsecond divider feeding the delay timer.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			tick_cnt_q <= 6'h00;
			us_tick_q  <= 1'b0;
		end else begin
			us_tick_q  <= (tick_cnt_q == 6'(`UTR_TICK_CYCLES - 1));
			tick_cnt_q <= (tick_cnt_q == 6'(`UTR_TICK_CYCLES - 1)) ? 6'h00 : tick_cnt_q + 6'h01;
		end
	end

	// One timer serves both the run-on time and the retry spacing.
	delay_timer u_timer (
		.clk_i     (CLK_I),
		.rst_i     (RESET_I),
		.start_i   (tmr_start),
		.us_tick_i (us_tick_q),
		.unit_us_i (UNIT_US_I),
		.units_i   (units),
		.done_o    (tmr_done)
	);

	// ======================================================================
	// Response sequencing. Shutdown by command or another fault has the
	// highest priority; a clear returns a faulted output to regulation.
	always_comb begin
		st_d      = st_q;
		tries_d   = tries_q;
		tmr_start = 1'b0;
		if (kill) begin
			st_d = ut_fault_pkg::ST_OFF;
		end else if (clr_evt && in_fault) begin
			st_d = ut_fault_pkg::ST_RUN;
		end else begin
			case (st_q)
				ut_fault_pkg::ST_OFF: begin
					if (on_rise) st_d = ut_fault_pkg::ST_RUN;
				end
				ut_fault_pkg::ST_RUN: begin
					if (UT_FAULT_I) begin
						case (cfg.resp)
							`UTR_RESP_IGNORE: st_d = ut_fault_pkg::ST_RUN;
							`UTR_RESP_RUNON: begin
								st_d      = ut_fault_pkg::ST_RUNON;
								tmr_start = 1'b1;
							end
							`UTR_RESP_RETRY: begin
								tries_d   = 3'h0;
								tmr_start = !no_retry;
								st_d      = no_retry ? ut_fault_pkg::ST_LATCH
								                     : ut_fault_pkg::ST_WAIT;
							end
							default: st_d = ut_fault_pkg::ST_LATCH;
						endcase
					end
				end
				ut_fault_pkg::ST_RUNON: begin
					if (tmr_done && !UT_FAULT_I) begin
						st_d = ut_fault_pkg::ST_RUN;
					end else if (tmr_done) begin
						tries_d   = 3'h0;
						tmr_start = !no_retry;
						st_d      = no_retry ? ut_fault_pkg::ST_LATCH : ut_fault_pkg::ST_WAIT;
					end
				end
				ut_fault_pkg::ST_WAIT: begin
					if (tmr_done && more_left) begin
						tries_d   = endless ? tries_q : tries_q + 3'h1;
						tmr_start = 1'b1;
						st_d      = ut_fault_pkg::ST_TRY;
					end else if (tmr_done) begin
						st_d = ut_fault_pkg::ST_LATCH;
					end
				end
				// An attempt that still finds the fault fails at once and drops the
				// output; the timer keeps running, so attempt starts stay one delay
				// apart. The price is a one-cycle enable pulse per failed attempt.
				ut_fault_pkg::ST_TRY: begin
					if (UT_FAULT_I) begin
						st_d = ut_fault_pkg::ST_WAIT;
					end else if (tmr_done) begin
						st_d = ut_fault_pkg::ST_RUN;
					end
				end
				ut_fault_pkg::ST_LATCH: st_d = ut_fault_pkg::ST_LATCH;
				default: st_d = ut_fault_pkg::ST_OFF;
			endcase
		end
	end

	// ======================================================================
	// State, enable and the sticky status bit, where a new fault wins
	// over a clear arriving in the same cycle.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			st_q     <= ut_fault_pkg::ST_OFF;
			tries_q  <= 3'h0;
			out_en_q <= 1'b0;
			sts_q    <= 1'b0;
			cmd_on_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			tries_q  <= tries_d;
			out_en_q <= (st_d == ut_fault_pkg::ST_RUN) || (st_d == ut_fault_pkg::ST_RUNON) ||
			            (st_d == ut_fault_pkg::ST_TRY);
			sts_q    <= UT_FAULT_I || (sts_q && !clr_evt && !on_rise);
			cmd_on_q <= cmd_on;
		end
	end

	// ======================================================================
	// Control pin synchroniser; only the second stage is read.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ctrl_s1_q <= 1'b0;
			ctrl_s2_q <= 1'b0;
		end else begin
			ctrl_s1_q <= CTRL_PIN_I;
			ctrl_s2_q <= ctrl_s1_q;
		end
	end

	// ======================================================================
	// Configuration byte access. Unknown codes get no acknowledge.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			cfg_q   <= `UTR_RESET_VAL;
			rdata_q <= 8'h00;
			ack_q   <= 1'b0;
		end else begin
			ack_q   <= hit && (CMD_WR_I || CMD_RD_I);
			rdata_q <= (hit && CMD_RD_I) ? cfg_q : 8'h00;
			if (hit && CMD_WR_I) cfg_q <= CMD_WDATA_I;
		end
	end

	// ======================================================================
	// Checks.
	wire quiet = !kill && !clr_evt;

	chk_ignore_stays_on: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_RUN && UT_FAULT_I && cfg.resp == `UTR_RESP_IGNORE && quiet
		|=> OUT_EN_O && st_q == ut_fault_pkg::ST_RUN)
		else $error("Ignored fault disturbed regulation.");

	chk_runon_keeps_on: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_RUN && UT_FAULT_I && cfg.resp == `UTR_RESP_RUNON && quiet
		|=> OUT_EN_O && st_q == ut_fault_pkg::ST_RUNON)
		else $error("Run-on response did not keep the output on.");

	chk_retry_disables: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_RUN && UT_FAULT_I && cfg.resp == `UTR_RESP_RETRY && quiet
		|=> !OUT_EN_O)
		else $error("Disable-and-retry left the output on.");

	chk_latch_holds: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_LATCH && quiet |=> st_q == ut_fault_pkg::ST_LATCH && !OUT_EN_O)
		else $error("Latched fault released without a clear.");

	chk_clear_status: assert property (@(posedge CLK_I) disable iff (RESET_I)
		clr_evt && !UT_FAULT_I |=> !FAULT_STS_O)
		else $error("Status not cleared.");

	chk_onoff_restarts: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_OFF && on_rise ##1 !kill |-> OUT_EN_O)
		else $error("Off-on cycle did not restore the output.");

	chk_no_retry_latch: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_RUN && UT_FAULT_I && cfg.resp == `UTR_RESP_RETRY &&
		no_retry && quiet |=> st_q == ut_fault_pkg::ST_LATCH)
		else $error("Zero retries did not latch off.");

	chk_attempt_limit: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_TRY && !endless |-> tries_q != 3'h0 && tries_q <= cfg.retries)
		else $error("Attempt count outside the retry setting.");

	chk_exhaust_latch: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_WAIT && tmr_done && !more_left && quiet
		|=> st_q == ut_fault_pkg::ST_LATCH && !OUT_EN_O)
		else $error("Exhausted retries did not hold the output off.");

	chk_forever_retry: assert property (@(posedge CLK_I) disable iff (RESET_I)
		st_q == ut_fault_pkg::ST_WAIT && tmr_done && endless && quiet
		|=> st_q == ut_fault_pkg::ST_TRY && OUT_EN_O)
		else $error("Continuous retry stopped.");

endmodule

/* shared/ut_fault_defs.svh */
// Purpose: Named constants for the under-temperature fault response block.
// Assumes: 40 MHz system clock; time unit supplied in microseconds.
// Notes:   Definitions only; included by bare name.
`ifndef UT_FAULT_DEFS_SVH
`define UT_FAULT_DEFS_SVH

// ==========================================================================
// Command codes and reset value.
`define UTR_CMD_CODE     8'h54
`define UTR_UNIT_CODE    8'hD2
`define UTR_RESET_VAL    8'h80

// ==========================================================================
// Field encodings of the configuration byte.
`define UTR_RESP_IGNORE  2'h0
`define UTR_RESP_RUNON   2'h1
`define UTR_RESP_RETRY   2'h2
`define UTR_RESP_LATCH   2'h3
`define UTR_RETRY_NONE   3'h0
`define UTR_RETRY_FOREVER 3'h7

// ==========================================================================
// Delay code to number of time units.
`define UTR_UNITS_0      8'h01
`define UTR_UNITS_1      8'h02
`define UTR_UNITS_2      8'h02
`define UTR_UNITS_3      8'h08
`define UTR_UNITS_4      8'h10
`define UTR_UNITS_5      8'h20
`define UTR_UNITS_6      8'h40
`define UTR_UNITS_7      8'h80

// ==========================================================================
// Timing: one microsecond tick derived from the clock.
`define UTR_CLK_NS       25
`define UTR_TICK_NS      1000
`define UTR_TICK_CYCLES  (`UTR_TICK_NS / `UTR_CLK_NS)

`endif

/* shared/ut_fault_pkg.sv */
// Purpose: Types for the under-temperature fault response block.
// Assumes: Field layout of the configuration byte is fixed.
// Notes:   Constants live in ut_fault_defs.svh.
package ut_fault_pkg;

	// ======================================================================
	// Configuration byte, most significant field first.
	typedef struct packed {
		logic [1:0] resp;
		logic [2:0] retries;
		logic [2:0] dly;
	} cfg_t;

	// ======================================================================
	// One-hot response states.
	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_RUN   = 6'h02,
		ST_RUNON = 6'h04,
		ST_WAIT  = 6'h08,
		ST_TRY   = 6'h10,
		ST_LATCH = 6'h20
	} state_t;

endpackage
